// ==== rtl/relay_pkg.sv ====
// constants, register map and types for the dual serial port relay
package relay_pkg;
	localparam int          CLK_HZ     = 25_000_000;
	localparam int          DEF_BAUD   = 9600;
	localparam logic [15:0] DEF_DIV    = 16'(CLK_HZ / DEF_BAUD);
	localparam int          FIFO_DEPTH = 64;
	localparam int          REC_DEPTH  = 64;
	localparam int          XOFF_AT    = 6;
	localparam int          FQ_DEPTH   = 4;
	localparam int          NP         = 2;
	localparam int          ADR_W      = 8;
	localparam int          MADR_W     = 16;
	localparam int          PORT_TERM  = 0;
	localparam int          PORT_HOST  = 1;
	// character defaults
	localparam logic [7:0]  DEF_XON    = 8'h11;
	localparam logic [7:0]  DEF_XOFF   = 8'h13;
	localparam logic [7:0]  DEF_ESC    = 8'h1b;
	localparam logic [7:0]  DEF_RESET  = 8'h1a;
	localparam logic [23:0] DEF_CHARS  = {DEF_RESET, DEF_XOFF, DEF_XON};
	localparam logic [15:0] DEF_ESCS   = {DEF_ESC, DEF_ESC};
	// register byte offsets
	localparam logic [7:0]  A_CTRL = 8'h00;
	localparam logic [7:0]  A_STAT = 8'h04;
	localparam logic [7:0]  A_TCFG = 8'h08;
	localparam logic [7:0]  A_HCFG = 8'h0c;
	localparam logic [7:0]  A_CHAR = 8'h10;
	localparam logic [7:0]  A_TESC = 8'h14;
	localparam logic [7:0]  A_HESC = 8'h18;
	localparam logic [7:0]  A_HRX  = 8'h1c;
	localparam logic [7:0]  A_TRX  = 8'h20;
	localparam logic [7:0]  A_HTX  = 8'h24;
	localparam logic [7:0]  A_TTX  = 8'h28;
	localparam logic [7:0]  A_RDAT = 8'h2c;
	localparam logic [7:0]  A_REND = 8'h30;
	// command bits of the control register
	localparam int C_GIVE_COMP = 0;
	localparam int C_GIVE_TERM = 1;
	localparam int C_PASS      = 2;
	localparam int C_DNL_ON    = 3;
	localparam int C_DNL_OFF   = 4;
	localparam int C_APPLY     = 5;
	// field positions
	localparam int F_DIV    = 0;
	localparam int F_LEN8   = 16;
	localparam int F_STOP2  = 17;
	localparam int F_PAREN  = 18;
	localparam int F_PARODD = 19;
	localparam int CFG_W    = 20;
	localparam logic [CFG_W-1:0] DEF_CFG = {4'h1, DEF_DIV};
	localparam int CH_XON   = 0;
	localparam int CH_XOFF  = 8;
	localparam int CH_RST   = 16;
	localparam int E_FIRST  = 0;
	localparam int E_SECOND = 8;
	localparam int REND_BASE = 16;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} rx_state_t;
endpackage : relay_pkg

// ==== rtl/serial_if.sv ====
// settings and byte handshake between relay core and one serial port
`timescale 1ns/1ps
interface serial_if;
	logic [15:0] div;
	logic        len8;
	logic        stop2;
	logic        par_en;
	logic        par_odd;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_err;
	modport port (input div, len8, stop2, par_en, par_odd, tx_valid,
		tx_data, output tx_ready, rx_valid, rx_data, rx_err);
	modport ctrl (output div, len8, stop2, par_en, par_odd, tx_valid,
		tx_data, input tx_ready, rx_valid, rx_data, rx_err);
endinterface : serial_if

// ==== rtl/serial_port.sv ====
// one asynchronous serial transmitter and receiver
`timescale 1ns/1ps
module serial_port (
	// system
	input  wire logic clk_i,
	input  wire logic rst_i,
	// line
	input  wire logic rxd_i,
	output logic      txd_o,
	// core side
	serial_if.port    sp
);
	import relay_pkg::*;

	function automatic logic [11:0] frame_f(input logic [7:0] d,
		input logic [3:0] nd, input logic pe, input logic po);
		logic [11:0] f;
		f = 12'hffe;
		for (int i = 0; i < 8; i++)
			if (4'(i) < nd)
				f[i + 1] = d[i];
		if (pe)
			f[nd + 4'h1] = (^d) ^ po;
		return f;
	endfunction : frame_f

	wire [3:0] nd    = sp.len8 ? 4'h8 : 4'h7;
	wire [7:0] tx_d  = sp.len8 ? sp.tx_data : {1'b0, sp.tx_data[6:0]};
	wire [3:0] nbits = 4'h3 + nd + {3'h0, sp.par_en} + {3'h0, sp.stop2};
	wire [3:0] last  = nd + {3'h0, sp.par_en};

	logic [11:0] tx_sh_q;
	logic [3:0]  tx_left_q;
	logic [15:0] tx_cnt_q;
	rx_state_t   rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [3:0]  rx_idx_q;
	logic [10:0] rx_buf_q;

	wire [7:0] rx_d  = sp.len8 ? rx_buf_q[7:0] : {1'b0, rx_buf_q[6:0]};
	wire       p_bad = sp.par_en & (rx_buf_q[nd] != ((^rx_d) ^ sp.par_odd));

	assign sp.tx_ready = (tx_left_q == 4'h0);

	// one spare slot after the stop bits keeps the last stop bit whole
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			txd_o     <= 1'b1;
			tx_sh_q   <= 12'hfff;
			tx_left_q <= 4'h0;
			tx_cnt_q  <= 16'h0;
		end
		else if (tx_left_q == 4'h0)
		begin
			txd_o <= 1'b1;
			if (sp.tx_valid)
			begin
				tx_sh_q   <= frame_f(tx_d, nd, sp.par_en, sp.par_odd);
				tx_left_q <= nbits;
				tx_cnt_q  <= 16'h0;
			end
		end
		else if (tx_cnt_q == 16'h0)
		begin
			txd_o     <= tx_sh_q[0];
			tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
			tx_cnt_q  <= sp.div - 16'h1;
			tx_left_q <= tx_left_q - 4'h1;
		end
		else
			tx_cnt_q <= tx_cnt_q - 16'h1;
	end

	// samples mid-bit, checks parity and first stop bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_st_q     <= RX_IDLE;
			rx_cnt_q    <= 16'h0;
			rx_idx_q    <= 4'h0;
			rx_buf_q    <= 11'h0;
			sp.rx_valid <= 1'b0;
			sp.rx_data  <= 8'h0;
			sp.rx_err   <= 1'b0;
		end
		else
		begin
			sp.rx_valid <= 1'b0;
			unique case (rx_st_q)
				RX_IDLE:
					if (!rxd_i)
					begin
						rx_cnt_q <= {1'b0, sp.div[15:1]};
						rx_st_q  <= RX_START;
					end
				RX_START:
					if (rx_cnt_q != 16'h0)
						rx_cnt_q <= rx_cnt_q - 16'h1;
					else if (rxd_i)
						rx_st_q <= RX_IDLE;
					else
					begin
						rx_cnt_q <= sp.div - 16'h1;
						rx_idx_q <= 4'h0;
						rx_st_q  <= RX_BITS;
					end
				RX_BITS:
					if (rx_cnt_q != 16'h0)
						rx_cnt_q <= rx_cnt_q - 16'h1;
					else if (rx_idx_q == last)
					begin
						sp.rx_valid <= 1'b1;
						sp.rx_data  <= rx_d;
						sp.rx_err   <= ~rxd_i | p_bad;
						rx_st_q     <= RX_IDLE;
					end
					else
					begin
						rx_buf_q[rx_idx_q] <= rxd_i;
						rx_idx_q <= rx_idx_q + 4'h1;
						rx_cnt_q <= sp.div - 16'h1;
					end
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end
endmodule : serial_port

// ==== rtl/dual_serial_port_relay.sv ====
// two-port serial relay core with flow control, passthrough and records
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module dual_serial_port_relay #(
	parameter int FIFO_DEPTH = 64,
	parameter int REC_DEPTH  = 64
) (
	// system
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [relay_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// serial lines
	input  wire logic                      term_rxd_i,
	output logic                           term_txd_o,
	output logic                           term_rts_o,
	input  wire logic                      host_rxd_i,
	output logic                           host_txd_o,
	output logic                           host_rts_o,
	// board selector, high selects the host port
	input  wire logic                      port_select_i,
	// target memory load
	output logic                           mem_we_o,
	output logic [relay_pkg::MADR_W-1:0]   mem_addr_o,
	output logic      [7:0]                mem_data_o,
	// device reset request
	output logic                           reset_req_o
);
	import relay_pkg::*;

	localparam int FW = $clog2(FIFO_DEPTH);
	localparam int RW = $clog2(REC_DEPTH + 1);

	function automatic logic [31:0] merge_f(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[i * 8 +: 8] = n[i * 8 +: 8];
		return o;
	endfunction : merge_f

	logic [CFG_W-1:0] cfg_q [NP];
	logic [CFG_W-1:0] act_q [NP];
	logic [23:0]      chars_q;
	logic [15:0]      esc_q [NP];
	logic             ctrl_q, init_q, pass_q, dnl_q, strap_q;
	logic [NP-1:0]    held_q, stop_q, fc_v_q, rts_q, sw_v_q;
	logic [7:0]       hch_q [NP];
	logic [7:0]       fc_q [NP];
	logic [7:0]       sw_q [NP];
	logic [7:0]       fq_q [NP][FQ_DEPTH];
	logic [1:0]       fq_wp_q [NP];
	logic [1:0]       fq_rp_q [NP];
	logic [2:0]       fq_cnt_q [NP];
	logic             xoff_sent_q, trx_v_q, reset_req_q;
	logic [7:0]       trx_q;
	logic [7:0]       fifo_q [FIFO_DEPTH];
	logic [FW-1:0]    fwp_q, frp_q;
	logic [FW:0]      fcnt_q;
	logic [7:0]       rec_q [REC_DEPTH];
	logic [RW-1:0]    rec_cnt_q, rec_idx_q;
	logic [7:0]       rec_sum_q;
	logic [MADR_W-1:0] rec_base_q;
	logic             rec_busy_q, rec_err_q;
	logic             ack_q;

	// bus decode
	wire req    = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr     = req & wb_we_i;
	wire rd     = req & ~wb_we_i;
	wire w_ctrl = wr & (wb_adr_i == A_CTRL);
	wire w_rdat = wr & (wb_adr_i == A_RDAT);
	wire w_rend = wr & (wb_adr_i == A_REND);
	wire w_char = wr & (wb_adr_i == A_CHAR);
	wire [NP-1:0] w_cfg = {wr & (wb_adr_i == A_HCFG),
		wr & (wb_adr_i == A_TCFG)};
	wire [NP-1:0] w_esc = {wr & (wb_adr_i == A_HESC),
		wr & (wb_adr_i == A_TESC)};
	wire [NP-1:0] w_tx = {wr & (wb_adr_i == A_HTX),
		wr & (wb_adr_i == A_TTX)};
	wire r_hrx  = rd & (wb_adr_i == A_HRX);
	wire r_trx  = rd & (wb_adr_i == A_TRX);
	wire hrx_v  = (fcnt_q != '0);

	// per-port wires
	wire [NP-1:0] rx_v, rx_xon, rx_xoff, rx_rst, rx_dat, tx_rdy, tx_go;
	wire [NP-1:0] pt_exit, pt_hold, pt_one, pt_two, fq_push, fq_nz;
	wire [NP-1:0] take_fc, take_fq, take_sw, txd, rxd;
	wire [7:0]    rx_b [NP];
	wire [7:0]    tx_byte [NP];
	wire [7:0]    fq_b0 [NP];
	wire [1:0]    fq_n [NP];

	assign rxd = {host_rxd_i, term_rxd_i};
	assign term_txd_o = txd[PORT_TERM];
	assign host_txd_o = txd[PORT_HOST];

	serial_if sp [NP] ();

	generate
		for (genvar p = 0; p < NP; p++)
		begin : g_port
			assign sp[p].div      = act_q[p][F_DIV +: 16];
			assign sp[p].len8     = act_q[p][F_LEN8];
			assign sp[p].stop2    = act_q[p][F_STOP2];
			assign sp[p].par_en   = act_q[p][F_PAREN];
			assign sp[p].par_odd  = act_q[p][F_PARODD];
			assign sp[p].tx_valid = tx_go[p];
			assign sp[p].tx_data  = tx_byte[p];
			assign rx_v[p]   = sp[p].rx_valid & ~sp[p].rx_err;
			assign rx_b[p]   = sp[p].rx_data;
			assign tx_rdy[p] = sp[p].tx_ready;

			// only flow, escape and reset codes are special
			assign rx_xon[p]  = rx_v[p] & (rx_b[p] == chars_q[CH_XON +: 8]);
			assign rx_xoff[p] = rx_v[p] &
				(rx_b[p] == chars_q[CH_XOFF +: 8]);
			assign rx_rst[p]  = rx_v[p] & (rx_b[p] == chars_q[CH_RST +: 8]);
			assign rx_dat[p]  = rx_v[p] & ~rx_xon[p] & ~rx_xoff[p] &
				~rx_rst[p];
			assign pt_exit[p] = rx_dat[p] & pass_q & held_q[p] &
				(rx_b[p] == esc_q[p][E_SECOND +: 8]);
			assign pt_hold[p] = rx_dat[p] & pass_q & ~held_q[p] &
				(rx_b[p] == esc_q[p][E_FIRST +: 8]);
			assign pt_two[p]  = rx_dat[p] & pass_q & held_q[p] &
				~pt_exit[p];
			assign pt_one[p]  = rx_dat[p] & pass_q & ~held_q[p] &
				~pt_hold[p];
			// traffic from this port lands in the other port's queue
			assign fq_n[1 - p]  = pt_two[p] ? 2'h2 : pt_one[p] ? 2'h1 : 2'h0;
			assign fq_b0[1 - p] = pt_two[p] ? hch_q[p] : rx_b[p];

			// queue full drops the new characters
			assign fq_push[p] = (fq_n[p] != 2'h0) &
				((fq_cnt_q[p] + {1'b0, fq_n[p]}) <= 3'(FQ_DEPTH));
			assign fq_nz[p]   = (fq_cnt_q[p] != 3'h0);
			// flow characters bypass the stop; data waits
			assign tx_go[p]   = fc_v_q[p] |
				(~stop_q[p] & (fq_nz[p] | sw_v_q[p]));
			assign tx_byte[p] = fc_v_q[p] ? fc_q[p] :
				fq_nz[p] ? fq_q[p][fq_rp_q[p]] : sw_q[p];
			assign take_fc[p] = tx_go[p] & tx_rdy[p] & fc_v_q[p];
			assign take_fq[p] = tx_go[p] & tx_rdy[p] & ~fc_v_q[p] & fq_nz[p];
			assign take_sw[p] = tx_go[p] & tx_rdy[p] & ~fc_v_q[p] &
				~fq_nz[p];

			serial_port u_port (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.rxd_i (rxd[p]),
				.txd_o (txd[p]),
				.sp    (sp[p])
			);
		end
	endgenerate

	// host receive buffer
	wire f_push = rx_dat[PORT_HOST] & ~pass_q &
		(fcnt_q != (FW + 1)'(FIFO_DEPTH));
	wire f_pop  = r_hrx & hrx_v;
	wire xoff_due = dnl_q & ~xoff_sent_q &
		(fcnt_q >= (FW + 1)'(XOFF_AT));
	wire xon_due  = xoff_sent_q & ~hrx_v & ~fc_v_q[PORT_HOST];

	// record load
	wire [7:0] rec_total = rec_sum_q + wb_dat_i[7:0];
	wire rec_add  = w_rdat & ~rec_busy_q & (rec_cnt_q != RW'(REC_DEPTH));
	wire rec_go   = w_rend & ~rec_busy_q & (rec_total == 8'h00) &
		(rec_cnt_q != '0);
	wire rec_last = (rec_idx_q == rec_cnt_q - 1'b1);

	wire [31:0] rd_word =
		(wb_adr_i == A_CTRL) ? 32'({rec_busy_q, rec_err_q, stop_q, dnl_q,
			pass_q, ctrl_q}) :
		(wb_adr_i == A_STAT) ? 32'({trx_v_q, fcnt_q}) :
		(wb_adr_i == A_TCFG) ? 32'(cfg_q[PORT_TERM]) :
		(wb_adr_i == A_HCFG) ? 32'(cfg_q[PORT_HOST]) :
		(wb_adr_i == A_CHAR) ? 32'(chars_q) :
		(wb_adr_i == A_TESC) ? 32'(esc_q[PORT_TERM]) :
		(wb_adr_i == A_HESC) ? 32'(esc_q[PORT_HOST]) :
		(wb_adr_i == A_HRX)  ? 32'({hrx_v, fifo_q[frp_q]}) :
		(wb_adr_i == A_TRX)  ? 32'({trx_v_q, trx_q}) : 32'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			ack_q    <= req;
			wb_dat_o <= rd ? rd_word : 32'h0;
		end
	end
	assign wb_ack_o = ack_q;

	// saved settings and characters
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			chars_q <= DEF_CHARS;
			for (int p = 0; p < NP; p++)
			begin
				cfg_q[p] <= DEF_CFG;
				esc_q[p] <= DEF_ESCS;
			end
		end
		else
		begin
			if (w_char)
				chars_q <= 24'(merge_f(32'(chars_q), wb_dat_i, wb_sel_i));
			for (int p = 0; p < NP; p++)
			begin
				if (w_cfg[p])
					cfg_q[p] <= CFG_W'(merge_f(32'(cfg_q[p]), wb_dat_i,
						wb_sel_i));
				if (w_esc[p])
					esc_q[p] <= 16'(merge_f(32'(esc_q[p]), wb_dat_i,
						wb_sel_i));
			end
		end
	end

	// control port, modes, held escapes, terminal input
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q      <= 1'b0;
			strap_q     <= 1'b1;
			init_q      <= 1'b0;
			pass_q      <= 1'b0;
			dnl_q       <= 1'b0;
			held_q      <= '0;
			reset_req_q <= 1'b0;
			trx_v_q     <= 1'b0;
			trx_q       <= 8'h0;
			for (int p = 0; p < NP; p++)
			begin
				hch_q[p] <= 8'h0;
				act_q[p] <= DEF_CFG;
			end
		end
		else
		begin
			strap_q     <= 1'b0;
			reset_req_q <= |rx_rst;
			if (strap_q)
				ctrl_q <= port_select_i;
			// one command register for both ports
			if (w_ctrl & wb_dat_i[C_GIVE_COMP])
				ctrl_q <= 1'b1;
			if (w_ctrl & wb_dat_i[C_GIVE_TERM])
				ctrl_q <= 1'b0;
			if (w_ctrl & wb_dat_i[C_PASS] & ~pass_q)
			begin
				pass_q <= 1'b1;
				init_q <= ctrl_q;
			end
			if (w_ctrl & wb_dat_i[C_DNL_ON])
				dnl_q <= 1'b1;
			if (w_ctrl & wb_dat_i[C_DNL_OFF])
				dnl_q <= 1'b0;
			for (int p = 0; p < NP; p++)
			begin
				if (pt_hold[p])
				begin
					held_q[p] <= 1'b1;
					hch_q[p]  <= rx_b[p];
				end
				if (pt_two[p] | pt_exit[p] | ~pass_q)
					held_q[p] <= 1'b0;
				if (w_ctrl & wb_dat_i[C_APPLY] | (|rx_rst))
					act_q[p] <= cfg_q[p];
			end
			if (|pt_exit)
			begin
				pass_q <= 1'b0;
				ctrl_q <= init_q;
			end
			if (|rx_rst)
			begin
				pass_q <= 1'b0;
				dnl_q  <= 1'b0;
			end
			if (r_trx)
				trx_v_q <= 1'b0;
			if (rx_dat[PORT_TERM] & ~pass_q)
			begin
				trx_v_q <= 1'b1;
				trx_q   <= rx_b[PORT_TERM];
			end
		end
	end

	// flow control state and flow character sending
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stop_q      <= '0;
			fc_v_q      <= '0;
			rts_q       <= '1;
			xoff_sent_q <= 1'b0;
			for (int p = 0; p < NP; p++)
				fc_q[p] <= 8'h0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (take_fc[p])
				begin
					fc_v_q[p] <= 1'b0;
					rts_q[p]  <= (fc_q[p] != chars_q[CH_XOFF +: 8]);
				end
				if (rx_xon[p])
					stop_q[p] <= 1'b0;
				if (rx_xoff[p])
					stop_q[p] <= 1'b1;
			end
			if (xoff_due)
			begin
				fc_v_q[PORT_HOST] <= 1'b1;
				fc_q[PORT_HOST]   <= chars_q[CH_XOFF +: 8];
				xoff_sent_q       <= 1'b1;
			end
			else if (xon_due)
			begin
				fc_v_q[PORT_HOST] <= 1'b1;
				fc_q[PORT_HOST]   <= chars_q[CH_XON +: 8];
				xoff_sent_q       <= 1'b0;
			end
		end
	end
	assign term_rts_o = rts_q[PORT_TERM];
	assign host_rts_o = rts_q[PORT_HOST];

	// passthrough queues and software transmit bytes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sw_v_q <= '0;
			for (int p = 0; p < NP; p++)
			begin
				fq_wp_q[p]  <= 2'h0;
				fq_rp_q[p]  <= 2'h0;
				fq_cnt_q[p] <= 3'h0;
				sw_q[p]     <= 8'h0;
			end
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (take_sw[p])
					sw_v_q[p] <= 1'b0;
				if (w_tx[p] & ~sw_v_q[p])
				begin
					sw_v_q[p] <= 1'b1;
					sw_q[p]   <= wb_dat_i[7:0];
				end
				if (take_fq[p])
					fq_rp_q[p] <= fq_rp_q[p] + 2'h1;
				if (fq_push[p])
				begin
					fq_q[p][fq_wp_q[p]] <= fq_b0[p];
					if (fq_n[p] == 2'h2)
						fq_q[p][fq_wp_q[p] + 2'h1] <= rx_b[1 - p];
					fq_wp_q[p] <= fq_wp_q[p] + fq_n[p];
				end
				fq_cnt_q[p] <= fq_cnt_q[p] +
					(fq_push[p] ? {1'b0, fq_n[p]} : 3'h0) -
					{2'h0, take_fq[p]};
			end
		end
	end

	// host receive buffer storage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fwp_q  <= '0;
			frp_q  <= '0;
			fcnt_q <= '0;
		end
		else
		begin
			if (f_push)
			begin
				fifo_q[fwp_q] <= rx_b[PORT_HOST];
				fwp_q <= fwp_q + 1'b1;
			end
			if (f_pop)
				frp_q <= frp_q + 1'b1;
			fcnt_q <= fcnt_q + {{FW{1'b0}}, f_push} - {{FW{1'b0}}, f_pop};
		end
	end

	// record holding and checked load into target memory
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rec_cnt_q  <= '0;
			rec_idx_q  <= '0;
			rec_sum_q  <= 8'h0;
			rec_base_q <= '0;
			rec_busy_q <= 1'b0;
			rec_err_q  <= 1'b0;
			mem_we_o   <= 1'b0;
			mem_addr_o <= '0;
			mem_data_o <= 8'h0;
		end
		else
		begin
			mem_we_o <= 1'b0;
			if (rec_add)
			begin
				rec_q[rec_cnt_q[RW-2:0]] <= wb_dat_i[7:0];
				rec_cnt_q <= rec_cnt_q + 1'b1;
				rec_sum_q <= rec_total;
			end
			if (w_rend & ~rec_busy_q)
			begin
				rec_err_q  <= ~rec_go;
				rec_busy_q <= rec_go;
				rec_idx_q  <= '0;
				rec_base_q <= wb_dat_i[REND_BASE +: MADR_W];
				if (!rec_go)
				begin
					rec_cnt_q <= '0;
					rec_sum_q <= 8'h0;
				end
			end
			if (rec_busy_q)
			begin
				mem_we_o   <= 1'b1;
				mem_addr_o <= rec_base_q + MADR_W'(rec_idx_q);
				mem_data_o <= rec_q[rec_idx_q[RW-2:0]];
				rec_idx_q  <= rec_idx_q + 1'b1;
				if (rec_last)
				begin
					rec_busy_q <= 1'b0;
					rec_cnt_q  <= '0;
					rec_sum_q  <= 8'h0;
				end
			end
		end
	end
	assign reset_req_o = reset_req_q;
endmodule : dual_serial_port_relay

// ==== test/relay_asserts.sv ====
// port-level assertions for the serial relay
`timescale 1ns/1ps
module relay_asserts (
	input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        term_txd_o, term_rts_o, host_txd_o, host_rts_o,
	input wire logic        mem_we_o, reset_req_o,
	input wire logic [15:0] mem_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	property p_ack_src; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_rst_idle; disable iff (1'b0) rst_i |=> term_txd_o &&
		host_txd_o && host_rts_o && !mem_we_o && !reset_req_o; endproperty
	property p_term_rts; term_rts_o; endproperty
	property p_rreq_pulse; reset_req_o |=> !reset_req_o; endproperty
	property p_mem_seq; mem_we_o && $past(mem_we_o) |->
		mem_addr_o == $past(mem_addr_o) + 16'h1; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	a_ack_resp: assert property (p_ack_resp) else $error("no ack");
	a_ack_src: assert property (p_ack_src) else $error("stray ack");
	a_dat_zero: assert property (p_dat_zero) else $error("data w/o ack");
	a_rst_idle: assert property (p_rst_idle) else $error("bad reset");
	a_term_rts: assert property (p_term_rts) else $error("term rts");
	a_rreq_pulse: assert property (p_rreq_pulse) else $error("rreq");
	a_mem_seq: assert property (p_mem_seq) else $error("mem addr");
	c_load: cover property (mem_we_o ##1 mem_we_o);
	c_rreq: cover property (reset_req_o);
	c_rts: cover property ($fell(host_rts_o));
endmodule : relay_asserts
bind dual_serial_port_relay relay_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .wb_dat_o, .term_txd_o, .term_rts_o, .host_txd_o,
	.host_rts_o, .mem_we_o, .reset_req_o, .mem_addr_o);

// ==== test/serial_station.sv ====
// behavioural terminal or host station, 8N1
`timescale 1ns/1ps
module serial_station #(
	parameter int DIV = 8
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [7:0] rxq[$];
	logic [7:0] sh;
	initial line_o = 1'b1;
	// sends one 8N1 frame, DIV clocks per bit; flow-off is not obeyed
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i) line_o <= f[i];
			repeat (DIV - 1) @(posedge clk_i);
		end
	endtask : send
	// receive only, no echo back
	initial
	forever
	begin
		@(negedge line_i);
		repeat (DIV / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (DIV) @(posedge clk_i);
			sh[i] = line_i;
		end
		repeat (DIV) @(posedge clk_i);
		rxq.push_back(sh);
	end
endmodule : serial_station

// ==== test/dual_serial_port_relay_tb.sv ====
// register and serial tests for the relay
`timescale 1ns/1ps
module dual_serial_port_relay_tb;
	import relay_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, trx, hrx, ack, ttx, trts, htx, hrts, mwe, rreq;
	logic [7:0]  adr = 8'h0, mdat;
	logic [31:0] dwr = 32'h0, rd, dat;
	logic [15:0] madr;
	logic [23:0] la = 24'h0;
	logic [3:0]  sel = 4'h0, wsel = 4'hf;
	logic        psel = 1'b0;
	int          err_count = 0, checks_done = 0, n_we = 0, n_rr = 0;
	initial forever #20 clk_i = ~clk_i;
	dual_serial_port_relay u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dwr), .wb_dat_o(dat), .wb_ack_o(ack), .term_rxd_i(trx),
		.term_txd_o(ttx), .term_rts_o(trts), .host_rxd_i(hrx),
		.host_txd_o(htx), .host_rts_o(hrts), .port_select_i(psel),
		.mem_we_o(mwe), .mem_addr_o(madr), .mem_data_o(mdat),
		.reset_req_o(rreq));
	serial_station u_term (.clk_i, .line_i(ttx), .line_o(trx));
	serial_station u_host (.clk_i, .line_i(htx), .line_o(hrx));
	always @(posedge clk_i) n_we <= n_we + int'(mwe === 1'b1);
	always @(posedge clk_i) n_rr <= n_rr + int'(rreq === 1'b1);
	always @(posedge clk_i) la <= (mwe === 1'b1) ? {madr, mdat} : la;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD t=%0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, dwr} <= {2'b11, w, a, wsel, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
		begin
			err_count++;
			tally_and_finish;
		end
		rd = dat;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic rx(input bit h, input logic [7:0] e);
		int n;
		n = 0;
		while ((h ? u_host.rxq.size() : u_term.rxq.size()) == 0 && n < 4000)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000)
		begin
			err_count++;
			tally_and_finish;
		end
		chk(h ? u_host.rxq.pop_front() : u_term.rxq.pop_front(), e);
	endtask : rx
	initial
	begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, A_CTRL, 0); chk(rd & 32'h1, 32'h0);
		wb(0, A_CHAR, 0); chk(rd & 32'hffffff, 32'h1a1311);
		wb(0, A_TESC, 0); chk(rd & 32'hffff, 32'h1b1b);
		wb(0, 8'h3c, 0); chk(rd, 32'h0);
		wb(1, A_CTRL, 1); wb(1, A_CTRL, 1);
		wb(0, A_CTRL, 0); chk(rd & 32'h1, 32'h1);
		wb(1, A_CTRL, 2); wb(1, A_CTRL, 2);
		wb(0, A_CTRL, 0); chk(rd & 32'h1, 32'h0);
		$display("test defaults and control done");
		wb(1, A_TCFG, 32'h10008); wb(1, A_HCFG, 32'h10008);
		wb(1, A_CTRL, 32'h20); wb(1, A_CTRL, 1); wb(1, A_CTRL, 4);
		wb(0, A_CTRL, 0); chk(rd & 32'h3, 32'h3);
		u_host.send(8'h41); rx(0, 8'h41);
		u_term.send(DEF_XOFF);
		u_host.send(8'h43);
		repeat (200) @(posedge clk_i);
		chk(u_term.rxq.size(), 0);
		u_term.send(DEF_XON);
		rx(0, 8'h43);
		u_term.send(8'h1b); repeat (200) @(posedge clk_i);
		chk(u_host.rxq.size(), 0);
		u_term.send(8'h42); rx(1, 8'h1b); rx(1, 8'h42);
		u_term.send(8'h1b); u_term.send(8'h1b); repeat (200) @(posedge clk_i);
		chk(u_host.rxq.size(), 0);
		wb(0, A_CTRL, 0); chk(rd & 32'h3, 32'h1);
		$display("test passthrough done");
		wb(1, A_CTRL, 32'h8);
		for (int i = 0; i < 6; i++)
			u_host.send(8'h60 + 8'(i));
		rx(1, DEF_XOFF); chk(hrts, 0);
		for (int i = 0; i < 6; i++)
		begin
			wb(0, A_HRX, 0); chk(rd & 32'h1ff, 32'h160 + i);
		end
		rx(1, DEF_XON); chk(hrts, 1);
		wb(1, A_CTRL, 32'h10);
		$display("test download flow done");
		wb(1, A_RDAT, 32'h10); wb(1, A_RDAT, 32'h20);
		wb(1, A_REND, 32'h010000d0); repeat (20) @(posedge clk_i);
		chk(n_we, 2); chk(la, 24'h010120);
		wb(1, A_RDAT, 32'h10); wb(1, A_REND, 32'h01000000);
		repeat (20) @(posedge clk_i); chk(n_we, 2);
		wb(0, A_CTRL, 0); chk(rd & 32'h20, 32'h20);
		u_host.send(DEF_RESET); repeat (20) @(posedge clk_i);
		chk(n_rr, 1);
		$display("test records and reset char done");
		wsel = 4'h1;
		wb(1, A_CHAR, 32'hff);
		wsel = 4'hf;
		wb(0, A_CHAR, 0); chk(rd & 32'hffffff, 32'h1a13ff);
		psel <= 1'b1;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, A_CTRL, 0); chk(rd & 32'h1, 32'h1);
		wb(0, A_CHAR, 0); chk(rd & 32'hffffff, 32'h1a1311);
		$display("test byte select and selector reset done");
		tally_and_finish;
	end
endmodule : dual_serial_port_relay_tb
